// File: logic/stall_counter.sv
// Purpose: counts stall cycles of one access and flags a time-out
// Assumes: start and ack come from logic on mclk
// Notes:   an access that times out while disabled keeps waiting for ack
`timescale 1ns/1ps
`default_nettype none
module stall_counter (
  // clock and reset
  input  wire logic     mclk,
  input  wire logic     rst_b,
  // monitored access
  stall_if.counter      ch
);
  timeout_pkg::stall_state_t state_q;
  timeout_pkg::stall_state_t state_d;
  logic [timeout_pkg::CNT_W-1:0] cnt_q;
  logic [timeout_pkg::CNT_W-1:0] cnt_d;
  logic                          timeout_q;
  logic                          limitHit;
  logic                          fire;

  assign limitHit   = (state_q == timeout_pkg::ST_WAIT) && !ch.ack &&
                      (cnt_q == timeout_pkg::STALL_LIMIT_CNT); // R11
  assign fire       = limitHit && ch.enable;
  assign ch.timeout = timeout_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      timeout_pkg::ST_IDLE: begin
        cnt_d = '0;
        if (ch.start) begin
          state_d = timeout_pkg::ST_WAIT; // R11
        end
      end
      timeout_pkg::ST_WAIT: begin
        if (ch.ack || fire) begin
          state_d = timeout_pkg::ST_IDLE; // R11
          cnt_d   = '0;
        end else if (!limitHit) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = timeout_pkg::ST_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q   <= timeout_pkg::ST_IDLE;
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      timeout_q <= fire; // R1 R4 R8
    end
  end

  property p_fire;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == timeout_pkg::ST_WAIT && !ch.ack && ch.enable &&
       cnt_q == timeout_pkg::STALL_LIMIT_CNT) |=> ch.timeout;
  endproperty
  a_fire: assert property (p_fire) else $error("stall limit reached without time-out"); // R11

  property p_cause;
    @(posedge mclk) disable iff (!rst_b)
      ch.timeout |-> $past(ch.enable) && $past(cnt_q) == timeout_pkg::STALL_LIMIT_CNT;
  endproperty
  a_cause: assert property (p_cause) else $error("time-out without full stall or enable"); // R8

  property p_ackend;
    @(posedge mclk) disable iff (!rst_b)
      (state_q == timeout_pkg::ST_WAIT && ch.ack) |=> state_q == timeout_pkg::ST_IDLE && !ch.timeout;
  endproperty
  a_ackend: assert property (p_ackend) else $error("ack did not end the access"); // R11
endmodule
`default_nettype wire

// File: logic/stall_if.sv
// Purpose: carries one monitored access between monitor and stall counter
// Assumes: single clock domain
// Notes:   timeout is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface stall_if;
  logic start;
  logic ack;
  logic enable;
  logic timeout;
  modport counter (input start, input ack, input enable, output timeout);
  modport monitor (output start, output ack, output enable, input timeout);
endinterface
`default_nettype wire

// File: logic/timeout_monitor.sv
// Purpose: bus access time-out monitor with its time-out control register
// Assumes: request, ack and register strobes are synchronous to mclk
// Notes:   accesses to active peripherals are not presented to this block
// Functional notes
// R1 - cpu/dma access to idle peripheral unacked 512 cycles gives time-out when enabled
// R2 - cpu time-out raises a cpu bus error through the bus error interrupt
// R3 - dma time-out makes dma set its status time-out flag and raise error
// R4 - external memory stall beyond 512 cycles errors only while its enable is 1
// R5 - software should leave the external memory check disabled
// R6 - external memory enable is control bit 1, read/write, resets to 0
// R7 - peripheral enable is control bit 0, read/write, resets to 1
// R8 - with peripheral enable clear no peripheral time-out error is produced
// R9 - control register at word address 0x9000, 16 bits, bits 15-2 read zero
// R10 - cache fetch time-out sets the fetch time-out flag, gated by external enable
// R11 - stall counter starts at issue, clears at ack, flags and ends on limit; with the channel enable clear it holds at the limit and waits for ack
`timescale 1ns/1ps
`default_nettype none
module timeout_monitor (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // peripheral register port
  input  wire logic [15:0] regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  // cpu access to disabled or idle peripheral
  input  wire logic        cpuPeriphStart,
  input  wire logic        cpuPeriphAck,
  // dma access to disabled or idle peripheral
  input  wire logic        dmaPeriphStart,
  input  wire logic        dmaPeriphAck,
  // external memory interface data access
  input  wire logic        extDataStart,
  input  wire logic        extDataAck,
  // instruction cache fetch from external memory
  input  wire logic        extFetchStart,
  input  wire logic        extFetchAck,
  input  wire logic        fetchFlagClr,
  // error answers
  output logic             cpuTimeoutErr,
  output logic             dmaTimeoutErr,
  output logic             extDataTimeoutErr,
  output logic             extFetchTimeoutErr,
  output logic             busErrorIrq,
  output logic             dmaChannelTimeout,
  output logic             cacheFetchTimeoutFlag
);
  logic [1:0]  ctrl_q;
  logic [1:0]  ctrl_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        fetchFlag_q;
  logic        fetchFlag_d;
  logic        ctrlHit;
  logic        periphEn;
  logic        extmemEn;
  logic [timeout_pkg::NUM_CH-1:0] chStart;
  logic [timeout_pkg::NUM_CH-1:0] chAck;
  logic [timeout_pkg::NUM_CH-1:0] chEn;
  logic [timeout_pkg::NUM_CH-1:0] chTimeout;

  function automatic logic addrHit(input logic [15:0] a);
    addrHit = (a == timeout_pkg::CTRL_ADDR);
  endfunction

  // register decode and control bits
  assign ctrlHit  = addrHit(regAddr); // R9
  assign periphEn = ctrl_q[timeout_pkg::CTRL_PERIPH_BIT];
  assign extmemEn = ctrl_q[timeout_pkg::CTRL_EXTMEM_BIT];
  assign ctrl_d   = (regWr && ctrlHit) ? regWdata[1:0] : ctrl_q; // R6 R7
  assign rdata_d  = (regRd && ctrlHit) ? {timeout_pkg::CTRL_RSVD_READ, ctrl_q} : 16'h0000; // R9

  // channel wiring
  assign chStart[timeout_pkg::CH_CPU_PERIPH] = cpuPeriphStart;
  assign chStart[timeout_pkg::CH_DMA_PERIPH] = dmaPeriphStart;
  assign chStart[timeout_pkg::CH_EXT_DATA]   = extDataStart;
  assign chStart[timeout_pkg::CH_EXT_FETCH]  = extFetchStart;
  assign chAck[timeout_pkg::CH_CPU_PERIPH]   = cpuPeriphAck;
  assign chAck[timeout_pkg::CH_DMA_PERIPH]   = dmaPeriphAck;
  assign chAck[timeout_pkg::CH_EXT_DATA]     = extDataAck;
  assign chAck[timeout_pkg::CH_EXT_FETCH]    = extFetchAck;
  assign chEn[timeout_pkg::CH_CPU_PERIPH]    = periphEn; // R1 R8
  assign chEn[timeout_pkg::CH_DMA_PERIPH]    = periphEn; // R1
  assign chEn[timeout_pkg::CH_EXT_DATA]      = extmemEn; // R4
  assign chEn[timeout_pkg::CH_EXT_FETCH]     = extmemEn; // R10

  genvar gi;
  generate
    for (gi = 0; gi < timeout_pkg::NUM_CH; gi++) begin : g_ch
      stall_if ch ();
      assign ch.start      = chStart[gi];
      assign ch.ack        = chAck[gi];
      assign ch.enable     = chEn[gi];
      assign chTimeout[gi] = ch.timeout;
      stall_counter u_cnt (
        .mclk  (mclk),
        .rst_b (rst_b),
        .ch    (ch)
      );
    end
  endgenerate

  // error routing; each pulse also terminates the access at the master
  assign cpuTimeoutErr      = chTimeout[timeout_pkg::CH_CPU_PERIPH]; // R1
  assign dmaTimeoutErr      = chTimeout[timeout_pkg::CH_DMA_PERIPH]; // R1
  assign extDataTimeoutErr  = chTimeout[timeout_pkg::CH_EXT_DATA]; // R4
  assign extFetchTimeoutErr = chTimeout[timeout_pkg::CH_EXT_FETCH]; // R10
  assign busErrorIrq        = cpuTimeoutErr || extDataTimeoutErr; // R2
  assign dmaChannelTimeout  = dmaTimeoutErr; // R3

  // fetch flag: a set in the clearing cycle wins
  assign fetchFlag_d = extFetchTimeoutErr || (fetchFlag_q && !fetchFlagClr); // R10

  assign regRdata              = rdata_q;
  assign cacheFetchTimeoutFlag = fetchFlag_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_q      <= timeout_pkg::CTRL_RESET; // R6 R7
      rdata_q     <= 16'h0000;
      fetchFlag_q <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      rdata_q     <= rdata_d;
      fetchFlag_q <= fetchFlag_d;
    end
  end

  property p_reset_val;
    @(posedge mclk) $rose(rst_b) |-> ctrl_q == 2'h1;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("control reset value wrong"); // R7

  property p_ext_reset;
    @(posedge mclk) $rose(rst_b) |-> !extmemEn;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("external enable not off at reset"); // R6

  property p_write;
    @(posedge mclk) disable iff (!rst_b)
      (regWr && regAddr == 16'h9000) |=> ctrl_q == $past(regWdata[1:0]);
  endproperty
  a_write: assert property (p_write) else $error("control write not stored"); // R6

  property p_read;
    @(posedge mclk) disable iff (!rst_b)
      (regRd && regAddr == 16'h9000 && !regWr) |=> regRdata == {14'h0000, $past(ctrl_q)};
  endproperty
  a_read: assert property (p_read) else $error("control readback wrong"); // R9

  property p_periph_off;
    @(posedge mclk) disable iff (!rst_b)
      (cpuTimeoutErr || dmaTimeoutErr) |-> $past(periphEn);
  endproperty
  a_periph_off: assert property (p_periph_off) else $error("peripheral time-out while disabled"); // R8

  property p_ext_off;
    @(posedge mclk) disable iff (!rst_b)
      (extDataTimeoutErr || extFetchTimeoutErr) |-> $past(extmemEn);
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("external time-out while disabled"); // R4

  property p_bus_error_interrupt;
    @(posedge mclk) disable iff (!rst_b)
      cpuTimeoutErr |-> busErrorIrq;
  endproperty
  a_bus_error_interrupt: assert property (p_bus_error_interrupt) else $error("cpu time-out without bus error"); // R2

  property p_dma;
    @(posedge mclk) disable iff (!rst_b)
      dmaTimeoutErr |-> dmaChannelTimeout;
  endproperty
  a_dma: assert property (p_dma) else $error("dma time-out not reported"); // R3

  sequence s_fetch_to;
    extFetchTimeoutErr;
  endsequence
  sequence s_flag_held;
    cacheFetchTimeoutFlag;
  endsequence
  property p_fetch_flag;
    @(posedge mclk) disable iff (!rst_b)
      s_fetch_to |=> cacheFetchTimeoutFlag ##1
        (cacheFetchTimeoutFlag || $past(fetchFlagClr));
  endproperty
  a_fetch_flag: assert property (p_fetch_flag) else $error("fetch time-out flag not set"); // R10

  // a flag that has stood two cycles without a clear is still set in the next cycle
  property p_flag_stick;
    @(posedge mclk) disable iff (!rst_b)
      (cacheFetchTimeoutFlag && !fetchFlagClr) [*2] |=> s_flag_held;
  endproperty
  a_flag_stick: assert property (p_flag_stick) else $error("fetch flag lost without clear"); // R10

  property p_flag_clear;
    @(posedge mclk) disable iff (!rst_b)
      (fetchFlagClr && !extFetchTimeoutErr) |=> !cacheFetchTimeoutFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("fetch flag not cleared"); // R10

  property p_irq_ext;
    @(posedge mclk) disable iff (!rst_b)
      extDataTimeoutErr |-> busErrorIrq;
  endproperty
  a_irq_ext: assert property (p_irq_ext) else $error("data time-out without bus error"); // R2

  property p_irq_cause;
    @(posedge mclk) disable iff (!rst_b)
      busErrorIrq |-> cpuTimeoutErr || extDataTimeoutErr;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("bus error without time-out"); // R2

  property p_dma_cause;
    @(posedge mclk) disable iff (!rst_b)
      dmaChannelTimeout |-> dmaTimeoutErr;
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma time-out flag without cause"); // R3

  property p_ignore_other;
    @(posedge mclk) disable iff (!rst_b)
      (regWr && regAddr != timeout_pkg::CTRL_ADDR) |=> ctrl_q == $past(ctrl_q);
  endproperty
  a_ignore_other: assert property (p_ignore_other) else $error("unmapped write changed control"); // R9

  property p_rd_idle;
    @(posedge mclk) disable iff (!rst_b)
      !regRd |=> regRdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero without read"); // R9
endmodule
`default_nettype wire

// File: logic/timeout_pkg.sv
// Purpose: shared constants for the bus access time-out monitor
// Assumes: 16-bit peripheral register port, word addressed
// Notes:   channel indices order the stall counters in the monitor
package timeout_pkg;
  // register map
  localparam logic [15:0] CTRL_ADDR       = 16'h9000;
  localparam int          CTRL_PERIPH_BIT = 0;
  localparam int          CTRL_EXTMEM_BIT = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h1;
  localparam logic [13:0] CTRL_RSVD_READ  = 14'h0000;

  // stall limit in cpu clock cycles
  localparam int          STALL_LIMIT     = 512;
  localparam int          CNT_W           = 10;
  localparam logic [9:0]  STALL_LIMIT_CNT = 10'(STALL_LIMIT);

  // monitored channels
  localparam int          NUM_CH          = 4;
  localparam int          CH_CPU_PERIPH   = 0;
  localparam int          CH_DMA_PERIPH   = 1;
  localparam int          CH_EXT_DATA     = 2;
  localparam int          CH_EXT_FETCH    = 3;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } stall_state_t;
endpackage

// File: testbench/access_partner.sv
// Purpose: far-side model that answers monitored accesses
// Assumes: start pulses are sampled on the rising edge of mclk
// Notes:   ackDelay of zero models a disabled or idle module that never answers
`timescale 1ns/1ps
`default_nettype none
module access_partner (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // accesses and their answers
  input  wire logic [3:0] start,
  input  wire logic [9:0] ackDelay,
  output logic      [3:0] ack
);
  logic [9:0] cnt [4];
  initial ack = 4'h0;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b || ack[i]) cnt[i] <= 10'h000;
      else if (start[i]) cnt[i] <= 10'h001;
      else if (cnt[i] != 10'h000) cnt[i] <= cnt[i] + 10'h001;
    end
  end
  // answer in the cycle that matches the programmed delay
  always @(negedge mclk) begin
    for (int i = 0; i < 4; i++) ack[i] <= (ackDelay != 10'h000) && (cnt[i] == ackDelay);
  end
endmodule
`default_nettype wire

// File: testbench/tb_bus_access_timeout_monitor.sv
// Purpose: self-checking bench for the bus access time-out monitor
// Assumes: inputs change on the falling edge of mclk
// Notes:   three control settings, each run over all four channels
`timescale 1ns/1ps
`default_nettype none
module tb_bus_access_timeout_monitor;
  logic        mclk;
  logic        rst_b;
  logic [15:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic [15:0] v;
  logic        regWr;
  logic        regRd;
  logic        fetchFlagClr;
  logic [3:0]  start;
  logic [3:0]  ack;
  wire  [3:0]  err;
  logic [9:0]  ackDelay;
  logic [1:0]  ctrl;
  logic        busErrorIrq;
  logic        dmaChannelTimeout;
  logic        cacheFetchTimeoutFlag;
  int          failures;
  int          n_tests;

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  timeout_monitor i_timeout_monitor (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWdata(regWdata), .regRdata(regRdata),
    .cpuPeriphStart(start[0]), .cpuPeriphAck(ack[0]),
    .dmaPeriphStart(start[1]), .dmaPeriphAck(ack[1]),
    .extDataStart(start[2]), .extDataAck(ack[2]),
    .extFetchStart(start[3]), .extFetchAck(ack[3]), .fetchFlagClr(fetchFlagClr),
    .cpuTimeoutErr(err[0]), .dmaTimeoutErr(err[1]), .extDataTimeoutErr(err[2]),
    .extFetchTimeoutErr(err[3]), .busErrorIrq(busErrorIrq),
    .dmaChannelTimeout(dmaChannelTimeout), .cacheFetchTimeoutFlag(cacheFetchTimeoutFlag)
  );

  access_partner i_access_partner (
    .mclk(mclk), .rst_b(rst_b), .start(start), .ackDelay(ackDelay), .ack(ack)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(negedge mclk);
    regWr = 1'b0;
  endtask

  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge mclk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge mclk);
    regRd = 1'b0;
    d = regRdata;
  endtask

  // one access; exp is the cycle of the time-out pulse, zero for none
  // clrAt raises the fetch flag clear in that cycle
  task automatic run_ch(input int ch, input logic [9:0] d, input logic [15:0] exp,
                        input int clrAt = 0);
    logic [15:0] hit;
    logic [15:0] nHigh;
    logic [3:0]  seen;
    hit = 16'h0000;
    nHigh = 16'h0000;
    seen = 4'h0;
    ackDelay = d;
    @(negedge mclk);
    start[ch] = 1'b1;
    for (int n = 1; n <= 600; n++) begin
      @(negedge mclk);
      start = 4'h0;
      fetchFlagClr = (n == clrAt);
      seen = seen | err;
      if (err[ch] === 1'b1) nHigh = nHigh + 16'h0001;
      if (err[ch] === 1'b1 && hit == 16'h0000) begin
        hit = 16'(n);
        check(16'(busErrorIrq), 16'(ch == 0 || ch == 2));
        check(16'(dmaChannelTimeout), 16'(ch == 1));
      end
    end
    check(hit, exp);
    check(nHigh, 16'(exp != 16'h0000));
    check(16'(seen), (exp != 16'h0000) ? 16'(4'h1 << ch) : 16'h0000);
    check(16'(cacheFetchTimeoutFlag), 16'(ch == 3 && exp != 16'h0000));
    @(negedge mclk);
    fetchFlagClr = 1'b1;
    @(negedge mclk);
    fetchFlagClr = 1'b0;
    check(16'(cacheFetchTimeoutFlag), 16'h0000);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1ms;
    failures++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0;
    regAddr = 16'h0000;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    fetchFlagClr = 1'b0;
    start = 4'h0;
    ackDelay = 10'h000;
    failures = 0;
    n_tests = 0;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    reg_rd(16'h9000, v);
    check(v, 16'h0001);
    reg_rd(16'h9001, v);
    check(v, 16'h0000);
    $display("test reset values done");
    for (int p = 0; p < 3; p++) begin
      ctrl = 2'(p + 1);
      if (p > 0) reg_wr(16'h9000, {14'h3fff, ctrl});
      reg_wr(16'h9002, 16'h0000);
      reg_rd(16'h9000, v);
      check(v, {14'h0000, ctrl});
      for (int ch = 0; ch < 4; ch++) begin
        if (p == 2) run_ch(ch, 10'h201, 16'h0000);
        else if (ctrl[ch >= 2]) run_ch(ch, 10'h000, 16'h0202, 514);
        else run_ch(ch, 10'h258, 16'h0000);
      end
      $display("test control setting %0d done", ctrl);
    end
    // reset again in mid-run; control returns to its reset value
    @(negedge mclk);
    rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    reg_rd(16'h9000, v);
    check(v, 16'h0001);
    $display("test mid-run reset done");
    // leave the external memory check off
    reg_wr(16'h9000, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire
